// File: hdl/pof_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Mask bit forces inactive, before polarity
// - Mask writes buffered, applied per sync
// - Mask works only in combine mode
// - Fault control needs enable and nonzero mode
// - Four fault inputs, per-input enables, shared filter
// - Synchronise then filter with 5-bit counter
// - Reverting input resets filter, drops glitches
// - Filter bypassed when value zero or disabled
// - Filtered delay grows with filter value
// - Rising edge sets flag; summary ORs flags
// - Fault edge forces pair to polarity value
// - Interrupt while summary flag and enable
// - Summary cleared by read one, write zero
// - Auto mode re-enables at input low, cycle
// - Manual mode re-enables after clear, cycle
// - Polarity bit selects output sense, combine only
// - Init write feeds init values of combined channels through mask and polarity
// - Counter match on selected combined channel triggers, needs enable
// - Counter initial-value load triggers
// - Capture test loads counter and channel values
module pof_top
    import pof_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Register port
    input  wire pof_bus_t              bus,
    output logic [DW-1:0]              rdata,
    // Counter side
    input  wire pof_cnt_in_t           cnt_in,
    input  wire logic [NCH-1:0][CW-1:0] chan_value,
    input  wire logic                  mask_sync_strobe,
    input  wire logic                  pwm_cycle_start,
    output pof_cnt_out_t               cnt_out,
    output pof_cap_t                   cap_out,
    // Channel signals
    input  wire logic [NCH-1:0]        pwm_raw,
    output logic [NCH-1:0]             chan_out,
    // Fault pins
    input  wire logic [NFLT-1:0]       fault_pin,
    // Triggers and interrupt
    output logic                       chan_trigger,
    output logic                       init_trigger,
    output logic                       fault_irq
);

    // ******************************************************************
    // Helpers
    // ******************************************************************
    function automatic logic is_comb(input logic [NPAIR-1:0] comb, input int ch);
        is_comb = comb[ch/2];
    endfunction : is_comb

    function automatic logic wr_at(input pof_bus_t b, input logic [AW-1:0] ofs);
        wr_at = b.wr && (b.addr == ofs);
    endfunction : wr_at

    pof_state_t s_r;
    pof_state_t s_nxt;

    logic              fc_active;
    logic [NFLT-1:0]   rise;
    logic [NFLT-1:0]   lvl_new;
    logic              or_new;
    logic              fsum;
    logic              cnt_wr;
    logic [DW-1:0]     rd_mux;
    logic              g;

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        s_nxt     = s_r;
        fc_active = s_r.fen && (s_r.fmode != FM_OFF);
        rise      = '0;
        lvl_new   = s_r.flvl;
        or_new    = 1'b0;
        cnt_wr    = 1'b0;
        rd_mux    = RST_BYTE;
        g         = 1'b0;

        // Single-cycle outputs fall back to idle
        s_nxt.cnt.load    = 1'b0;
        s_nxt.cnt.advance = 1'b0;
        s_nxt.cap.load    = 1'b0;
        s_nxt.cap.flag_set = '0;
        s_nxt.ctrig       = 1'b0;
        s_nxt.itrig       = 1'b0;
        s_nxt.rdata       = RST_BYTE;

        // Plain register writes
        if (wr_at(bus, OFS_MODE)) begin
            s_nxt.fen     = bus.wdata[B_FEN];
            s_nxt.ctest   = bus.wdata[B_CTEST];
            s_nxt.fmode   = bus.wdata[B_FMODE +: 2];
            s_nxt.fie     = bus.wdata[B_FIE];
        end
        if (wr_at(bus, OFS_COMBINE)) begin
            s_nxt.comb = bus.wdata[NPAIR-1:0];
            s_nxt.pfen = bus.wdata[B_PFEN +: NPAIR];
        end
        if (wr_at(bus, OFS_MASK)) begin
            s_nxt.mbuf = bus.wdata[NCH-1:0];
        end
        if (wr_at(bus, OFS_POL)) begin
            s_nxt.pol = bus.wdata[NCH-1:0];
        end
        if (wr_at(bus, OFS_OUTINIT)) begin
            s_nxt.oinit = bus.wdata[NCH-1:0];
        end
        if (wr_at(bus, OFS_FLTCTRL)) begin
            s_nxt.fin_en = bus.wdata[NFLT-1:0];
            s_nxt.ffl_en = bus.wdata[B_FFEN +: NFLT];
        end
        if (wr_at(bus, OFS_FLTFILT)) begin
            s_nxt.flen = bus.wdata[3:0];
        end
        if (wr_at(bus, OFS_TRIG)) begin
            s_nxt.tsel     = bus.wdata[NCH-1:0];
            s_nxt.itrig_en = bus.wdata[B_ITRIG];
        end
        if (wr_at(bus, OFS_SYNC)) begin
            s_nxt.msync = bus.wdata[0];
        end

        // Mask takes the buffer on the next edge or on the sync strobe
        if (!s_r.msync || mask_sync_strobe) begin
            s_nxt.mact = s_nxt.mbuf;
        end

        // Fault input conditioning
        for (int i = 0; i < NFLT; i++) begin
            s_nxt.sync[i] = {s_r.sync[i][1:0], fault_pin[i]};
            if (s_r.sync[i][2] == s_r.sync[i][1]) begin
                if (!s_r.fin_en[i] || !s_r.ffl_en[i] || (s_r.flen == 4'h0)) begin
                    lvl_new[i]   = s_r.sync[i][2];
                    s_nxt.fcnt[i] = '0;
                end else if (s_r.sync[i][2] == s_r.flvl[i]) begin
                    s_nxt.fcnt[i] = '0;
                end else if (s_r.fcnt[i] >= {1'b0, s_r.flen}) begin
                    lvl_new[i]   = s_r.sync[i][2];
                    s_nxt.fcnt[i] = '0;
                end else begin
                    s_nxt.fcnt[i] = s_r.fcnt[i] + 5'h01;
                end
            end
            rise[i] = lvl_new[i] && !s_r.flvl[i] && s_r.fin_en[i];
            or_new  = or_new | (lvl_new[i] && s_r.fin_en[i]);
        end
        s_nxt.flvl    = lvl_new;
        s_nxt.or_prev = or_new;

        // Clear needs a prior read of one; a new edge still wins
        if (bus.rd && (bus.addr == OFS_FLTSTAT) && (s_r.fflag != '0)) begin
            s_nxt.arm = 1'b1;
        end
        if (wr_at(bus, OFS_FLTSTAT) && !bus.wdata[B_FSUM] && s_r.arm) begin
            s_nxt.fflag = '0;
            s_nxt.arm   = 1'b0;
        end
        if (fc_active) begin
            s_nxt.fflag = s_nxt.fflag | rise;
        end
        fsum = (s_nxt.fflag != '0);

        // Output disable per pair
        for (int p = 0; p < NPAIR; p++) begin
            if (s_r.fdis[p] && pwm_cycle_start) begin
                if ((s_r.fmode == FM_AUTO) && !or_new) begin
                    s_nxt.fdis[p] = 1'b0;
                end else if ((s_r.fmode != FM_AUTO) && !fsum) begin
                    s_nxt.fdis[p] = 1'b0;
                end
            end
            if (fc_active && s_r.pfen[p] && s_r.comb[p] && or_new && !s_r.or_prev) begin
                s_nxt.fdis[p] = 1'b1;
            end
        end

        // Output chain: init, mask, polarity, fault
        for (int c = 0; c < NCH; c++) begin
            s_nxt.raw_prev[c] = pwm_raw[c];
            if (pwm_raw[c] != s_r.raw_prev[c]) begin
                s_nxt.init_hold[c] = 1'b0;
            end
            if (wr_at(bus, OFS_MODE) && bus.wdata[B_INIT] && is_comb(s_r.comb, c)) begin
                s_nxt.init_hold[c] = 1'b1;
            end
            g = pwm_raw[c];
            if (is_comb(s_r.comb, c)) begin
                if (s_nxt.init_hold[c]) begin
                    g = s_r.oinit[c];
                end
                g = g && !s_nxt.mact[c];
                g = g ^ s_r.pol[c];
                if (s_nxt.fdis[c/2]) begin
                    g = s_r.pol[c];
                end
            end
            s_nxt.out[c] = g;

            // Match trigger on entry into equality
            s_nxt.match_prev[c] = (cnt_in.value == chan_value[c]);
            if (s_r.fen && s_r.tsel[c] && is_comb(s_r.comb, c)
                && s_nxt.match_prev[c] && !s_r.match_prev[c]) begin
                s_nxt.ctrig = 1'b1;
            end
        end

        s_nxt.irq = fsum && s_nxt.fie;

        // Counter writes and capture test
        s_nxt.cnt.freeze = s_nxt.ctest;
        cnt_wr = wr_at(bus, OFS_CNTH) || wr_at(bus, OFS_CNTL);
        if (cnt_wr) begin
            if (s_r.ctest) begin
                if (wr_at(bus, OFS_CNTH)) begin
                    s_nxt.cbuf[CW-1:DW] = bus.wdata;
                    s_nxt.hi_w          = 1'b1;
                end else begin
                    s_nxt.cbuf[DW-1:0] = bus.wdata;
                    s_nxt.lo_w         = 1'b1;
                end
                s_nxt.cnt.load       = 1'b1;
                s_nxt.cnt.load_value = s_nxt.cbuf;
                if (s_nxt.hi_w && s_nxt.lo_w) begin
                    s_nxt.cap.load     = 1'b1;
                    s_nxt.cap.value    = s_nxt.cbuf;
                    s_nxt.cap.flag_set = '1;
                    s_nxt.cnt.advance  = 1'b1;
                    s_nxt.hi_w         = 1'b0;
                    s_nxt.lo_w         = 1'b0;
                end
            end else begin
                s_nxt.cnt.load       = 1'b1;
                s_nxt.cnt.load_value = cnt_in.init_value;
            end
        end
        if (!s_r.ctest) begin
            s_nxt.hi_w = 1'b0;
            s_nxt.lo_w = 1'b0;
        end

        if (wr_at(bus, OFS_CLKSEL)) begin
            s_nxt.cnt.csel = bus.wdata[1:0];
        end

        // Initial-value load trigger
        if (s_r.itrig_en) begin
            if (cnt_in.reload || cnt_in.sync || (cnt_wr && !s_r.ctest)) begin
                s_nxt.itrig = 1'b1;
            end
            if (wr_at(bus, OFS_CLKSEL) && (bus.wdata[1:0] != CNT_HALT)
                && (s_r.cnt.csel == CNT_HALT) && (cnt_in.value == cnt_in.init_value)) begin
                s_nxt.itrig = 1'b1;
            end
        end

        // Read data stands in the cycle after the strobe only
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_MODE:    rd_mux = {s_r.fie, 1'b0, s_r.fmode, 1'b0, s_r.ctest,
                                       1'b0, s_r.fen};
                OFS_COMBINE: rd_mux = {1'b0, s_r.pfen, 1'b0, s_r.comb};
                OFS_MASK:    rd_mux = {2'h0, s_r.mbuf};
                OFS_POL:     rd_mux = {2'h0, s_r.pol};
                OFS_OUTINIT: rd_mux = {2'h0, s_r.oinit};
                OFS_FLTCTRL: rd_mux = {s_r.ffl_en, s_r.fin_en};
                OFS_FLTFILT: rd_mux = {4'h0, s_r.flen};
                OFS_FLTSTAT: rd_mux = {(s_r.fflag != '0), 1'b0, s_r.or_prev, 1'b0,
                                       s_r.fflag};
                OFS_TRIG:    rd_mux = {1'b0, s_r.itrig_en, s_r.tsel};
                OFS_SYNC:    rd_mux = {7'h00, s_r.msync};
                OFS_CNTH:    rd_mux = cnt_in.value[CW-1:DW];
                OFS_CNTL:    rd_mux = cnt_in.value[DW-1:0];
                OFS_CLKSEL:  rd_mux = {6'h00, s_r.cnt.csel};
                default:     rd_mux = RST_BYTE;
            endcase
            s_nxt.rdata = rd_mux;
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata        = s_r.rdata;
    assign cnt_out      = s_r.cnt;
    assign cap_out      = s_r.cap;
    assign chan_out     = s_r.out;
    assign chan_trigger = s_r.ctrig;
    assign init_trigger = s_r.itrig;
    assign fault_irq    = s_r.irq;

endmodule : pof_top

// File: include/pof_pkg.sv
package pof_pkg;

    // ******************************************************************
    // Sizes
    // ******************************************************************
    localparam int NCH   = 6;
    localparam int NPAIR = 3;
    localparam int NFLT  = 4;
    localparam int CW    = 16;
    localparam int DW    = 8;
    localparam int AW    = 4;
    localparam int FCW   = 5;

    // ******************************************************************
    // Register offsets
    // ******************************************************************
    localparam logic [AW-1:0] OFS_MODE    = 4'h0;
    localparam logic [AW-1:0] OFS_COMBINE = 4'h1;
    localparam logic [AW-1:0] OFS_MASK    = 4'h2;
    localparam logic [AW-1:0] OFS_POL     = 4'h3;
    localparam logic [AW-1:0] OFS_OUTINIT = 4'h4;
    localparam logic [AW-1:0] OFS_FLTCTRL = 4'h5;
    localparam logic [AW-1:0] OFS_FLTFILT = 4'h6;
    localparam logic [AW-1:0] OFS_FLTSTAT = 4'h7;
    localparam logic [AW-1:0] OFS_TRIG    = 4'h8;
    localparam logic [AW-1:0] OFS_SYNC    = 4'h9;
    localparam logic [AW-1:0] OFS_CNTH    = 4'hA;
    localparam logic [AW-1:0] OFS_CNTL    = 4'hB;
    localparam logic [AW-1:0] OFS_CLKSEL  = 4'hC;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int B_FEN     = 0;
    localparam int B_INIT    = 1;
    localparam int B_CTEST   = 2;
    localparam int B_FMODE   = 3;
    localparam int B_FIE     = 7;
    localparam int B_PFEN    = 4;
    localparam int B_FFEN    = 4;
    localparam int B_FSTAT   = 5;
    localparam int B_FSUM    = 7;
    localparam int B_ITRIG   = 6;

    // ******************************************************************
    // Fault modes, counter halt select and reset values
    // ******************************************************************
    localparam logic [1:0] FM_OFF  = 2'h0;
    localparam logic [1:0] FM_AUTO = 2'h3;
    localparam logic [1:0] CNT_HALT  = 2'h0;
    localparam logic [DW-1:0] RST_BYTE = 8'h00;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } pof_bus_t;

    typedef struct packed {
        logic [CW-1:0] value;
        logic [CW-1:0] init_value;
        logic          reload;
        logic          sync;
    } pof_cnt_in_t;

    typedef struct packed {
        logic          load;
        logic [CW-1:0] load_value;
        logic          freeze;
        logic          advance;
        logic [1:0]    csel;
    } pof_cnt_out_t;

    typedef struct packed {
        logic           load;
        logic [CW-1:0]  value;
        logic [NCH-1:0] flag_set;
    } pof_cap_t;

    typedef struct packed {
        logic                      fen;
        logic                      fie;
        logic                      ctest;
        logic [1:0]                fmode;
        logic [NPAIR-1:0]          comb;
        logic [NPAIR-1:0]          pfen;
        logic [NCH-1:0]            mbuf;
        logic [NCH-1:0]            mact;
        logic [NCH-1:0]            pol;
        logic [NCH-1:0]            oinit;
        logic [NCH-1:0]            tsel;
        logic                      itrig_en;
        logic                      msync;
        logic [NFLT-1:0]           fin_en;
        logic [NFLT-1:0]           ffl_en;
        logic [3:0]                flen;
        logic [NFLT-1:0]           fflag;
        logic                      arm;
        logic [NFLT-1:0][2:0]      sync;
        logic [NFLT-1:0]           flvl;
        logic [NFLT-1:0][FCW-1:0]  fcnt;
        logic                      or_prev;
        logic [NPAIR-1:0]          fdis;
        logic [NCH-1:0]            init_hold;
        logic [NCH-1:0]            raw_prev;
        logic [NCH-1:0]            match_prev;
        logic [NCH-1:0]            out;
        logic                      ctrig;
        logic                      itrig;
        logic                      irq;
        logic                      hi_w;
        logic                      lo_w;
        logic [CW-1:0]             cbuf;
        pof_cnt_out_t              cnt;
        pof_cap_t                  cap;
        logic [DW-1:0]             rdata;
    } pof_state_t;

endpackage : pof_pkg

// File: test/pof_partner.sv
`timescale 1ns/10ps
module pof_partner
    import pof_pkg::*;
#(
    parameter logic [CW-1:0] TOP_COUNT = 16'h000F
)
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Block side
    input  wire pof_cnt_out_t           cnt_out,
    output pof_cnt_in_t                 cnt_in,
    output logic [NCH-1:0][CW-1:0]      chan_value,
    output logic [NCH-1:0]              pwm_raw,
    output logic                        mask_sync_strobe,
    output logic                        pwm_cycle_start
);
    logic [CW-1:0] cnt_r;
    logic          wrap_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= '0;
            wrap_r <= 1'b0;
        end else if (cnt_out.load) begin
            // A capture-test load and its single step arrive together
            cnt_r  <= cnt_out.load_value + {15'h0000, cnt_out.advance};
            wrap_r <= 1'b0;
        end else begin
            wrap_r <= 1'b0;
            // Counter halts with no clock source, so init happens stopped
            if ((cnt_out.csel != CNT_HALT && !cnt_out.freeze) || cnt_out.advance) begin
                wrap_r <= (cnt_r == TOP_COUNT);
                cnt_r  <= (cnt_r == TOP_COUNT) ? '0 : cnt_r + 16'h0001;
            end
        end
    end

    always_comb begin
        cnt_in           = '0;
        cnt_in.value     = cnt_r;
        cnt_in.reload    = wrap_r;
        mask_sync_strobe = wrap_r;
        pwm_cycle_start  = wrap_r;
        for (int i = 0; i < NCH; i++) begin
            chan_value[i] = CW'(2 + 2 * i);
            pwm_raw[i]    = cnt_r < chan_value[i];
        end
    end
endmodule : pof_partner

// File: test/pof_top_asserts.sv
`timescale 1ns/10ps
module pof_top_asserts
    import pof_pkg::*;
(
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst_n,
    // Register port
    input wire pof_bus_t               bus,
    input wire logic [DW-1:0]          rdata,
    // Counter side
    input wire pof_cnt_in_t            cnt_in,
    input wire logic [NCH-1:0][CW-1:0] chan_value,
    input wire logic                   mask_sync_strobe,
    input wire logic                   pwm_cycle_start,
    input wire pof_cnt_out_t           cnt_out,
    input wire pof_cap_t               cap_out,
    // Channels and faults
    input wire logic [NCH-1:0]         pwm_raw,
    input wire logic [NCH-1:0]         chan_out,
    input wire logic [NFLT-1:0]        fault_pin,
    // Triggers and interrupt
    input wire logic                   chan_trigger,
    input wire logic                   init_trigger,
    input wire logic                   fault_irq
);
    logic             wr_cnt;
    logic             init_src;
    logic             any_match;
    logic [NPAIR-1:0] comb_r;
    logic [NPAIR-1:0] comb_nxt;

    // Shadow of the combine bits, so pass-through is judged only where it applies
    always_comb begin
        wr_cnt    = bus.wr && (bus.addr == OFS_CNTH || bus.addr == OFS_CNTL);
        init_src  = wr_cnt || cnt_in.reload || cnt_in.sync;
        init_src  = init_src || (bus.wr && bus.addr == OFS_CLKSEL);
        any_match = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            any_match = any_match || (cnt_in.value == chan_value[i]);
        end
        comb_nxt = comb_r;
        if (bus.wr && bus.addr == OFS_COMBINE) begin
            comb_nxt = bus.wdata[NPAIR-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comb_r <= '0;
        end else begin
            comb_r <= comb_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == RST_BYTE)
        else $error("read data present without a read");
    a_irq_hold: assert property ($fell(fault_irq)
        |-> $past(bus.wr) || $past(bus.wr, 2) || $past(bus.wr, 3))
        else $error("interrupt dropped without a register write");
    a_cap_flags: assert property (cap_out.load
        |-> cap_out.flag_set == '1 && cnt_out.freeze)
        else $error("capture load without all flags or freeze");
    a_cap_cause: assert property (cap_out.load |-> $past(wr_cnt))
        else $error("capture load without a counter byte write");
    a_load_cause: assert property (cnt_out.load |-> $past(wr_cnt))
        else $error("counter load without a counter write");
    a_chan_trig: assert property (chan_trigger |-> $past(any_match))
        else $error("channel trigger without a match");
    a_init_trig: assert property (init_trigger |-> $past(init_src))
        else $error("init trigger without a cause");
    a_plain_pass: assert property ($past(rst_n) && comb_r == '0 && $past(comb_r) == '0
        |-> chan_out == $past(pwm_raw))
        else $error("plain channels not passed through");

    c_irq: cover property ($rose(fault_irq));
    c_cap: cover property (cap_out.load);
    c_itrig: cover property (init_trigger);
    c_ctrig: cover property (chan_trigger);
endmodule : pof_top_asserts

bind pof_top pof_top_asserts u_asserts (.*);

// File: test/pwm_output_fault_trigger_tb.sv
`timescale 1ns/10ps
module pwm_output_fault_trigger_tb
    import pof_pkg::*;
;
    logic                   clk, rst_n, mask_sync_strobe, pwm_cycle_start;
    logic                   chan_trigger, init_trigger, fault_irq;
    pof_bus_t               bus;
    logic [DW-1:0]          rdata;
    pof_cnt_in_t            cnt_in;
    pof_cnt_out_t           cnt_out;
    pof_cap_t               cap_out;
    logic [NCH-1:0][CW-1:0] chan_value;
    logic [NCH-1:0]         pwm_raw, chan_out;
    logic [NFLT-1:0]        fault_pin;
    int                     n_errors = 0;
    int                     n_checks = 0;

    pof_top dut (.*);
    pof_partner u_far (.*);

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd

    function automatic logic sig(input int s);
        case (s)
            0: return chan_trigger;
            1: return init_trigger;
            2: return pwm_cycle_start;
            3: return cap_out.load;
            4: return chan_out[0];
            default: return !chan_out[0];
        endcase
    endfunction : sig

    // Bounded wait; running out ends the run at once
    task automatic wait_hi(input int s, input int n);
        int i;
        #1;
        for (i = 0; i < n && sig(s) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i >= n) begin
            n_errors++;
            $display("BAD wait%0d expected 1 seen 0", s);
            test_done();
        end
    endtask : wait_hi

    task automatic park();
        wr(OFS_CLKSEL, 8'h00);
        wr(OFS_CNTL, 8'h00);
    endtask : park

    task automatic pulse(input logic [NFLT-1:0] p, input int n);
        @(posedge clk);
        fault_pin <= p;
        repeat (n) @(posedge clk);
        fault_pin <= '0;
    endtask : pulse

    task automatic t_regs();
        logic [7:0] d;
        rd(OFS_MODE, d);
        chk("mode_rst", d, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, d);
        chk("unmapped", d, 8'h00);
        wr(OFS_POL, 8'hFF);
        rd(OFS_POL, d);
        chk("pol_rb", d, 8'h3F);
        $display("test regs done");
    endtask : t_regs

    task automatic t_plain();
        logic [NCH-1:0] prev;
        wr(OFS_MASK, 8'h3F);
        wr(OFS_CLKSEL, 8'h01);
        #1 prev = pwm_raw;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1 chk("plain", chan_out, prev);
            prev = pwm_raw;
        end
        park();
        $display("test plain done");
    endtask : t_plain

    task automatic t_mask();
        wr(OFS_MASK, 8'h00);
        wr(OFS_COMBINE, 8'h01);
        wr(OFS_POL, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk("pol", chan_out[1:0], 2'b01);
        wr(OFS_MASK, 8'h03);
        repeat (2) @(posedge clk);
        #1 chk("mask", chan_out[1:0], 2'b10);
        wr(OFS_SYNC, 8'h01);
        wr(OFS_MASK, 8'h00);
        repeat (4) @(posedge clk);
        #1 chk("mask_buf", chan_out[1:0], 2'b10);
        wr(OFS_CLKSEL, 8'h01);
        wait_hi(4, 60);
        wr(OFS_SYNC, 8'h00);
        park();
        $display("test mask done");
    endtask : t_mask

    task automatic t_init();
        wr(OFS_POL, 8'h01);
        wr(OFS_OUTINIT, 8'h02);
        wr(OFS_MODE, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk("init", chan_out[1:0], 2'b11);
        $display("test init done");
    endtask : t_init

    task automatic t_trig();
        wr(OFS_TRIG, 8'h41);
        wr(OFS_MODE, 8'h01);
        wr(OFS_CNTL, 8'h00);
        wait_hi(1, 4);
        wr(OFS_CLKSEL, 8'h01);
        wait_hi(0, 40);
        chk("match_cnt", cnt_in.value[7:0], 8'h03);
        $display("test trig done");
    endtask : t_trig

    task automatic t_fault();
        logic [7:0] d;
        wr(OFS_COMBINE, 8'h11);
        wr(OFS_FLTCTRL, 8'h23);
        wr(OFS_FLTFILT, 8'h04);
        wr(OFS_MODE, 8'h89);
        pulse(4'h2, 3);
        repeat (12) @(posedge clk);
        rd(OFS_FLTSTAT, d);
        chk("glitch", d & 8'h83, 8'h00);
        pulse(4'h2, 20);
        repeat (12) @(posedge clk);
        wr(OFS_FLTSTAT, 8'h00);
        rd(OFS_FLTSTAT, d);
        chk("no_clear", d & 8'hA3, 8'h82);
        chk("irq_on", fault_irq, 1'b1);
        wait_hi(2, 40);
        repeat (3) @(posedge clk);
        #1 chk("safe", chan_out[1:0], 2'b01);
        wr(OFS_FLTSTAT, 8'h00);
        rd(OFS_FLTSTAT, d);
        chk("cleared", d & 8'h83, 8'h00);
        chk("irq_off", fault_irq, 1'b0);
        wait_hi(5, 60);
        pulse(4'h1, 2);
        repeat (10) @(posedge clk);
        rd(OFS_FLTSTAT, d);
        chk("bypass", d & 8'h01, 8'h01);
        chk("held", chan_out[0], 1'b1);
        // Automatic mode must re-enable with the flag still set
        wr(OFS_MODE, 8'h99);
        wait_hi(5, 60);
        $display("test fault done");
    endtask : t_fault

    task automatic t_cap();
        logic [15:0] v;
        logic [7:0]  b;
        wr(OFS_MODE, 8'h05);
        @(posedge clk);
        #1 chk("freeze", cnt_out.freeze, 1'b1);
        for (int k = 0; k < 2; k++) begin
            v = k ? 16'hA55A : 16'h1234;
            wr(k ? OFS_CNTL : OFS_CNTH, k ? v[7:0] : v[15:8]);
            wr(k ? OFS_CNTH : OFS_CNTL, k ? v[15:8] : v[7:0]);
            wait_hi(3, 4);
            chk("cap_hi", cap_out.value[15:8], v[15:8]);
            chk("cap_lo", cap_out.value[7:0], v[7:0]);
            chk("cap_flags", cap_out.flag_set, 6'h3F);
        end
        rd(OFS_CNTL, b);
        chk("cnt_step", b, 8'h5B);
        wr(OFS_MODE, 8'h00);
        $display("test capture done");
    endtask : t_cap

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        bus = '0;
        fault_pin = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_plain();
        t_mask();
        t_init();
        t_trig();
        t_fault();
        t_cap();
        test_done();
    end
endmodule : pwm_output_fault_trigger_tb
